/* File: design/key_watchdog.sv */
/*
  two-stage key watchdog: first stage raises an interrupt, second stage halts.
  assumes a single-cycle strobe register port and one 40 MHz clock.
*/
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module key_watchdog #(
  parameter logic [wdog_pkg::ADDR_W-1:0] BASE = wdog_pkg::BASE_DEF,
  parameter logic [wdog_pkg::DATA_W-1:0] SERVICE_KEY_WORD = wdog_pkg::KEY_DEF,
  parameter logic [wdog_pkg::CNT_W-1:0] FIRST_STAGE_PERIOD = wdog_pkg::FIRST_PERIOD_DEF,
  parameter logic [wdog_pkg::CNT_W-1:0] SECOND_STAGE_PERIOD = wdog_pkg::SECOND_PERIOD_DEF,
  parameter int IRQ_LINE_SELECT = wdog_pkg::IRQ_LINE_DEF,
  parameter logic [4:0] WAIT_STATES = wdog_pkg::WAITS_DEF,
  parameter bit START_AT_RESET_CFG = 1'b1,
  parameter bit RESUME_AFTER_EXPIRY_CFG = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [wdog_pkg::ADDR_W-1:0] addr_i,
  input wire logic [wdog_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [wdog_pkg::DATA_W-1:0] rdata_o,
  output logic stall_o,
  // interrupt and halt
  output logic [wdog_pkg::IRQ_LINES-1:0] irq_lines_o,
  output logic halt_o,
  output logic debugger_handoff_o
);
  import wdog_pkg::*;

  localparam wdog_state_t RESET_STATE = START_AT_RESET_CFG ? ST_STAGE1 : ST_IDLE;
  // values above the ceiling are clamped rather than trusted
  localparam logic [4:0] WAITS_USED =
    (WAIT_STATES > 5'(MAX_WAITS)) ? 5'(MAX_WAITS) : WAIT_STATES;
  // an out-of-range line number falls back to line 0 rather than indexing off the bus
  localparam int IRQ_LINE_USED =
    (IRQ_LINE_SELECT >= 0 && IRQ_LINE_SELECT < IRQ_LINES) ? IRQ_LINE_SELECT : 0;

  wdog_state_t state;
  wdog_state_t next_state;
  logic resume_after_expiry_cfg;
  logic [4:0] wait_cnt;
  logic hit;
  logic key_write;
  logic access;
  logic cfg_write;

  wdog_cnt_if first_if ();
  wdog_cnt_if second_if ();

  // each stage owns its reload value, so the core only says load and run
  stage_counter #(.PERIOD(FIRST_STAGE_PERIOD)) first_stage (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .ctl(first_if)
  );

  stage_counter #(.PERIOD(SECOND_STAGE_PERIOD)) second_stage (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .ctl(second_if)
  );

  function automatic logic in_window(input logic [ADDR_W-1:0] a);
    in_window = (a[ADDR_W-1:WIN_LSB] == BASE[ADDR_W-1:WIN_LSB]);
  endfunction : in_window

  function automatic logic at_ofs(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    at_ofs = in_window(a) && (a[WIN_LSB-1:0] == ofs);
  endfunction : at_ofs

  function automatic logic [DATA_W-1:0] status_word(input wdog_state_t s);
    status_word = '0;
    status_word[ST_STATE_LSB +: 2] = s;
    status_word[ST_IRQ_BIT] = (s == ST_STAGE2);
    status_word[ST_FIRED_BIT] = (s == ST_FIRED);
  endfunction : status_word

  function automatic logic [CNT_W-1:0] active_count(input wdog_state_t s,
      input logic [CNT_W-1:0] c1, input logic [CNT_W-1:0] c2);
    active_count = (s == ST_STAGE2) ? c2 : c1;
  endfunction : active_count

  assign hit = in_window(addr_i);
  assign access = (wr_i || rd_i) && hit;
  // only the exact word serves; any other value written at base is dropped
  assign key_write = wr_i && at_ofs(addr_i, KEY_OFS) &&
    (wdata_i == SERVICE_KEY_WORD);
  // the setting freezes once fired so the halt outcome cannot be rewritten
  assign cfg_write = wr_i && at_ofs(addr_i, CONFIG_OFS) && (state != ST_FIRED);

  // a key write wins over an expiry in the same cycle: software did serve it
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (key_write) begin
          next_state = ST_STAGE1;
        end
      end
      ST_STAGE1: begin
        if (!key_write && first_if.expire) begin
          next_state = ST_STAGE2;
        end
      end
      ST_STAGE2: begin
        if (key_write) begin
          next_state = ST_STAGE1;
        end else if (second_if.expire) begin
          next_state = ST_FIRED;
        end
      end
      ST_FIRED: begin
        next_state = ST_FIRED;
      end
    endcase
  end

  // fired is terminal: only the asynchronous reset leaves it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // first counter reloads on key writes only while not fired; second loads on entering stage 2
  assign first_if.load = key_write && state != ST_FIRED;
  assign first_if.run = (state == ST_STAGE1);
  assign second_if.load = (state == ST_STAGE1) && next_state == ST_STAGE2;
  assign second_if.run = (state == ST_STAGE2);

  // interrupt and halt outputs
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_lines_o <= '0;
    end else begin
      irq_lines_o <= '0;
      irq_lines_o[IRQ_LINE_USED] <= (next_state == ST_STAGE2);
    end
  end

  // halt stays until reset: the fired state is never left
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt_o <= 1'b0;
    end else begin
      halt_o <= (next_state == ST_FIRED);
    end
  end

  // handoff frozen at expiry so a config write in that cycle cannot flip it later
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      debugger_handoff_o <= 1'b0;
    end else if (state != ST_FIRED) begin
      debugger_handoff_o <= (next_state == ST_FIRED) && !resume_after_expiry_cfg;
    end
  end

  // resume setting, writable until the watchdog fires
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resume_after_expiry_cfg <= RESUME_AFTER_EXPIRY_CFG;
    end else if (cfg_write) begin
      resume_after_expiry_cfg <= wdata_i[CFG_RESUME_BIT];
    end
  end

  // wait states after each access
  // stall is advisory: read data is never held back by it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_cnt <= '0;
    end else if (access) begin
      wait_cnt <= WAITS_USED;
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 5'h01;
    end
  end

  assign stall_o = (wait_cnt != '0);

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (rd_i && hit) begin
      unique case (addr_i[3:0])
        STATUS_OFS: begin
          rdata_o <= status_word(state);
        end
        CONFIG_OFS: begin
          rdata_o <= '0;
          rdata_o[CFG_RESUME_BIT] <= resume_after_expiry_cfg;
        end
        COUNT_OFS: begin
          rdata_o <= '0;
          rdata_o[CNT_W-1:0] <= active_count(state, first_if.count, second_if.count);
        end
        default: begin
          rdata_o <= UNMAPPED_READ;
        end
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule : key_watchdog

/* File: design/stage_counter.sv */
/*
  one down counter of the watchdog, reloaded to its period on demand.
  assumes load and run come from the watchdog state machine.
*/
`timescale 1ns/100ps
module stage_counter #(
  parameter logic [wdog_pkg::CNT_W-1:0] PERIOD = wdog_pkg::FIRST_PERIOD_DEF
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // control from the core
  wdog_cnt_if.cnt ctl
);
  import wdog_pkg::*;

  logic [CNT_W-1:0] count;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= PERIOD;
    end else if (ctl.load) begin
      count <= PERIOD;
    end else if (ctl.run && count != '0) begin
      count <= count - CNT_W'(1);
    end
  end

  assign ctl.count = count;
  // last cycle of the period: a period of n gives expiry on the n-th run cycle
  assign ctl.expire = ctl.run && !ctl.load && (count == CNT_W'(1));
endmodule : stage_counter

/* File: design/wdog_cnt_if.sv */
/*
  control and status bundle between the watchdog core and one stage counter.
  assumes both ends share sys_clk_i.
*/
`timescale 1ns/100ps
interface wdog_cnt_if;
  import wdog_pkg::*;
  logic load;
  logic run;
  logic [CNT_W-1:0] count;
  logic expire;
  modport ctrl (output load, output run, input count, input expire);
  modport cnt (input load, input run, output count, output expire);
endinterface : wdog_cnt_if

/* File: design/wdog_pkg.sv */
/*
  constants shared by the two-stage key watchdog and its stage counter.
  assumes a 32-bit word bus with byte addresses and one 40 MHz clock.
*/
package wdog_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CNT_W = 24;
  // register offsets inside the decode window
  localparam logic [3:0] KEY_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] CONFIG_OFS = 4'h8;
  localparam logic [3:0] COUNT_OFS = 4'hC;
  localparam int WIN_LSB = 4;
  // status and config fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_IRQ_BIT = 2;
  localparam int ST_FIRED_BIT = 3;
  localparam int CFG_RESUME_BIT = 0;
  // build-time defaults
  localparam logic [ADDR_W-1:0] BASE_DEF = 32'hB0000000;
  localparam logic [DATA_W-1:0] KEY_DEF = 32'h12345678;
  localparam logic [CNT_W-1:0] FIRST_PERIOD_DEF = 24'h080000;
  localparam logic [CNT_W-1:0] SECOND_PERIOD_DEF = 24'h000BB8;
  localparam int IRQ_LINES = 32;
  localparam int IRQ_LINE_DEF = 16;
  localparam int MAX_WAITS = 30;
  localparam logic [4:0] WAITS_DEF = 5'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;
  // gray order along idle, first stage, second stage, fired
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STAGE1 = 2'b01,
    ST_STAGE2 = 2'b11,
    ST_FIRED = 2'b10
  } wdog_state_t;
endpackage : wdog_pkg

/* File: verif/key_watchdog_bench.sv */
/* self-checking bench for key_watchdog with short stage periods.
   assumes wdog_cpu_model as bus master and the bound checker. */
`timescale 1ns/100ps
module key_watchdog_bench;
  import wdog_pkg::*;
  localparam logic [31:0] B = BASE_DEF;
  logic sys_clk_i, resetn_i, wr, rd, stall, halt, handoff;
  logic [31:0] addr, wdata, rdata, irq, q;
  logic stall_b, halt_b, handoff_b;
  logic [31:0] rdata_b, irq_b;
  int n_errors = 0;
  int total_checks = 0;
  // short periods keep the run brief; expectations follow 16 and 8
  key_watchdog #(.FIRST_STAGE_PERIOD(24'h000010), .SECOND_STAGE_PERIOD(24'h000008),
    .WAIT_STATES(5'h02), .RESUME_AFTER_EXPIRY_CFG(1'b0)) u_dut (.sys_clk_i, .resetn_i,
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .stall_o(stall),
    .irq_lines_o(irq), .halt_o(halt), .debugger_handoff_o(handoff));
  // second build idles until keyed, has no wait states and may resume after expiry
  key_watchdog #(.FIRST_STAGE_PERIOD(24'h000010), .SECOND_STAGE_PERIOD(24'h000008),
    .START_AT_RESET_CFG(1'b0)) u_dut_idle (.sys_clk_i, .resetn_i,
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_b), .stall_o(stall_b),
    .irq_lines_o(irq_b), .halt_o(halt_b), .debugger_handoff_o(handoff_b));
  wdog_cpu_model u_cpu (.sys_clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_st(input logic [31:0] exp);
    u_cpu.acc(1'b0, B + 32'h4, 32'h0, q);
    chk(q, exp);
  endtask : rd_st
  task automatic wait_irq();
    repeat (40) if (irq[16] !== 1'b1) @(posedge sys_clk_i);
  endtask : wait_irq
  task automatic t_start();
    rd_st(32'h1);
    chk(rdata_b, 32'h0);
    u_cpu.acc(1'b0, B, 32'h0, q);
    chk(q, 32'h0);
    u_cpu.acc(1'b0, 32'hA0000004, 32'h0, q);
    chk(q, 32'h0);
    u_cpu.acc(1'b0, B + 32'hC, 32'h0, q);
    chk(q, 32'h9);
  endtask : t_start
  task automatic t_service();
    wait_irq();
    chk(irq, 32'h00010000);
    chk(irq_b, 32'h0);
    rd_st(32'h7);
    u_cpu.acc(1'b1, B, KEY_DEF, q);
    chk(irq, 32'h0);
    repeat (12) @(posedge sys_clk_i);
    chk({irq[31:1], halt}, 32'h0);
  endtask : t_service
  task automatic t_expire();
    wait_irq();
    repeat (20) if (halt !== 1'b1) @(posedge sys_clk_i);
    chk({30'h0, halt, handoff}, 32'h3);
    chk({30'h0, halt_b, handoff_b}, 32'h2);
    chk(irq, 32'h0);
    u_cpu.acc(1'b1, B, KEY_DEF, q);
    rd_st(32'hA);
    chk(rdata_b, 32'hA);
    @(posedge sys_clk_i) resetn_i <= 1'b0;
    @(posedge sys_clk_i) resetn_i <= 1'b1;
    rd_st(32'h1);
    chk({31'h0, halt}, 32'h0);
    chk(rdata_b, 32'h0);
  endtask : t_expire
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    resetn_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_start();
    t_service();
    t_expire();
    print_verdict();
  end
  // whole run needs some 60 cycles
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
endmodule : key_watchdog_bench

/* File: verif/key_watchdog_chk.sv */
/* port checker for key_watchdog, bound to every instance.
   the stall length check covers builds of at most two wait states. */
`timescale 1ns/100ps
module key_watchdog_chk import wdog_pkg::*; #(
  parameter logic [31:0] BASE = BASE_DEF,
  parameter logic [31:0] SERVICE_KEY_WORD = KEY_DEF,
  parameter int IRQ_LINE_SELECT = IRQ_LINE_DEF,
  parameter logic [4:0] WAIT_STATES = WAITS_DEF,
  parameter bit RESUME_AFTER_EXPIRY_CFG = 1'b1
) (
  // watched ports
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic stall_o,
  input wire logic [31:0] irq_lines_o,
  input wire logic halt_o,
  input wire logic debugger_handoff_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic win;
  assign win = addr_i[31:4] == BASE[31:4];
  sequence s_acc; (wr_i || rd_i) && win; endsequence
  sequence s_key; wr_i && win && addr_i[3:0] == KEY_OFS && wdata_i == SERVICE_KEY_WORD; endsequence
  irq_one_line_a: assert property ((irq_lines_o & ~(32'h1 << IRQ_LINE_SELECT)) == 0)
    else $error("irq off its line");
  halt_sticky_a: assert property (halt_o |=> halt_o) else $error("halt dropped");
  fire_from_irq_a: assert property ($rose(halt_o) |-> irq_lines_o == 0 &&
    $past(irq_lines_o[IRQ_LINE_SELECT])) else $error("halt without second stage");
  handoff_mode_a: assert property (debugger_handoff_o == (halt_o && !RESUME_AFTER_EXPIRY_CFG))
    else $error("handoff wrong");
  key_clears_a: assert property (s_key ##0 !halt_o |=> irq_lines_o == 0 && !halt_o)
    else $error("key did not clear");
  stall_on_a: assert property (s_acc |=> stall_o == (WAIT_STATES != 5'h00))
    else $error("wait state count wrong");
  stall_off_a: assert property (s_acc ##0 (WAIT_STATES <= 5'h02) ##1 !(wr_i || rd_i) [*2]
    |=> !stall_o) else $error("stall too long");
  rdata_idle_a: assert property (!(rd_i && win) |=> rdata_o == 0)
    else $error("read data outside a read");
endmodule : key_watchdog_chk
bind key_watchdog key_watchdog_chk #(.BASE(BASE), .SERVICE_KEY_WORD(SERVICE_KEY_WORD),
  .IRQ_LINE_SELECT(IRQ_LINE_SELECT), .WAIT_STATES(WAIT_STATES),
  .RESUME_AFTER_EXPIRY_CFG(RESUME_AFTER_EXPIRY_CFG))
  u_chk (.sys_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .stall_o,
  .irq_lines_o, .halt_o, .debugger_handoff_o);

/* File: verif/wdog_cpu_model.sv */
/* processor-side model driving the watchdog register port.
   assumes one clock and a slave that never waits. */
`timescale 1ns/100ps
module wdog_cpu_model (
  // clock
  input wire logic sys_clk_i,
  // register port
  output logic [31:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rdata_i
);
  initial begin
    addr_o = 32'h0;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one access; idle bus shows inverted values so stale data never match
  task automatic acc(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1 q = rdata_i;
  endtask : acc
endmodule : wdog_cpu_model
